/* File: hw/swt_pkg.sv */
// Constants for the status word transfer block: field positions, masks, modes,
// instruction fields and condition codes.
// Assumes a single clock domain and a core that presents one decoded instruction per cycle.
package swt_pkg;

  // ****************************************************************
  // Status word layout
  // ****************************************************************
  localparam int          SWT_FLAG_N_BIT  = 31;
  localparam int          SWT_FLAG_Z_BIT  = 30;
  localparam int          SWT_FLAG_C_BIT  = 29;
  localparam int          SWT_FLAG_V_BIT  = 28;
  localparam int          SWT_IRQ_DIS_BIT = 7;
  localparam int          SWT_FIQ_DIS_BIT = 6;
  localparam int          SWT_MODE_MSB    = 4;
  localparam logic [31:0] SWT_DEFINED_MASK = 32'hf00000df;
  localparam logic [31:0] SWT_FLAGS_MASK   = 32'hf0000000;
  localparam logic [31:0] SWT_CURRENT_RESET = 32'h000000d3;
  localparam logic [31:0] SWT_SAVED_RESET   = 32'h00000000;

  // ****************************************************************
  // Processor modes and saved word banks
  // ****************************************************************
  localparam logic [4:0] SWT_MODE_USER  = 5'h10;
  localparam logic [4:0] SWT_MODE_FIQ   = 5'h11;
  localparam logic [4:0] SWT_MODE_IRQ   = 5'h12;
  localparam logic [4:0] SWT_MODE_SVC   = 5'h13;
  localparam logic [4:0] SWT_MODE_ABORT = 5'h17;
  localparam logic [4:0] SWT_MODE_UNDEF = 5'h1b;
  localparam int         SWT_BANKS      = 5;

  // ****************************************************************
  // Instruction fields
  // ****************************************************************
  localparam int         SWT_COND_MSB   = 31;
  localparam int         SWT_COND_LSB   = 28;
  localparam int         SWT_CLASS_MSB  = 27;
  localparam int         SWT_CLASS_LSB  = 26;
  localparam int         SWT_IMM_BIT    = 25;
  localparam int         SWT_OPC_MSB    = 24;
  localparam int         SWT_OPC_LSB    = 23;
  localparam int         SWT_SAVED_BIT  = 22;
  localparam int         SWT_WRITE_BIT  = 21;
  localparam int         SWT_SETF_BIT   = 20;
  localparam int         SWT_FULL_BIT   = 16;
  localparam int         SWT_RD_MSB     = 15;
  localparam int         SWT_RD_LSB     = 12;
  localparam int         SWT_ROT_MSB    = 11;
  localparam int         SWT_ROT_LSB    = 8;
  localparam int         SWT_IMM8_MSB   = 7;
  localparam logic [1:0] SWT_CLASS_DP   = 2'h0;
  localparam logic [1:0] SWT_OPC_TEST   = 2'h2;
  localparam logic [3:0] SWT_DP_TST     = 4'h8;
  localparam logic [3:0] SWT_DP_CMN     = 4'hb;

  // ****************************************************************
  // Condition codes
  // ****************************************************************
  localparam logic [3:0] SWT_CC_EQ = 4'h0;
  localparam logic [3:0] SWT_CC_NE = 4'h1;
  localparam logic [3:0] SWT_CC_CS = 4'h2;
  localparam logic [3:0] SWT_CC_CC = 4'h3;
  localparam logic [3:0] SWT_CC_MI = 4'h4;
  localparam logic [3:0] SWT_CC_PL = 4'h5;
  localparam logic [3:0] SWT_CC_VS = 4'h6;
  localparam logic [3:0] SWT_CC_VC = 4'h7;
  localparam logic [3:0] SWT_CC_HI = 4'h8;
  localparam logic [3:0] SWT_CC_LS = 4'h9;
  localparam logic [3:0] SWT_CC_GE = 4'ha;
  localparam logic [3:0] SWT_CC_LT = 4'hb;
  localparam logic [3:0] SWT_CC_GT = 4'hc;
  localparam logic [3:0] SWT_CC_LE = 4'hd;
  localparam logic [3:0] SWT_CC_AL = 4'he;

endpackage

/* File: hw/swt_cond_eval.sv */
// Condition field evaluator for the status word transfer block.
// Assumes the flags input is the live condition flags of the current status word.
`timescale 1ns/1ps
module swt_cond_eval (
  // Condition and flags
  input  wire logic [3:0] cond_in,
  input  wire logic [3:0] flags_in,
  // Result
  output logic            pass_out
);
  import swt_pkg::*;

  logic n;
  logic z;
  logic c;
  logic v;

  assign n = flags_in[3];
  assign z = flags_in[2];
  assign c = flags_in[1];
  assign v = flags_in[0];

  always_comb begin
    unique case (cond_in)
      SWT_CC_EQ: pass_out = z;
      SWT_CC_NE: pass_out = !z;
      SWT_CC_CS: pass_out = c;
      SWT_CC_CC: pass_out = !c;
      SWT_CC_MI: pass_out = n;
      SWT_CC_PL: pass_out = !n;
      SWT_CC_VS: pass_out = v;
      SWT_CC_VC: pass_out = !v;
      SWT_CC_HI: pass_out = c && !z;
      SWT_CC_LS: pass_out = !c || z;
      SWT_CC_GE: pass_out = (n == v);
      SWT_CC_LT: pass_out = (n != v);
      SWT_CC_GT: pass_out = !z && (n == v);
      SWT_CC_LE: pass_out = z || (n != v);
      SWT_CC_AL: pass_out = 1'b1;
      default:   pass_out = 1'b0;
    endcase
  end

endmodule

/* File: hw/swt_status_word_transfer.sv */
// Status word transfer logic: current and banked saved status words, the read and
// write transfer instructions, flag updates from data processing and the restore on
// a flag-setting move into the program counter.
// Assumes the core delivers one instruction per cycle with its source operand ready.
//
// Functional notes
// - Transfer executes only when its condition passes; otherwise nothing changes.
// - Transfers decode from test and compare opcodes with set-flags bit clear.
// - Read copies current or mode's saved word into the destination register.
// - Full write moves source register into current or mode's saved word.
// - Flags-only write copies source top four bits, control bits unchanged.
// - In user mode only flags of the current word can change.
// - Saved word bank is chosen by the mode in force at execution.
// - Eleven defined bits: four flags, two disables, five mode bits.
// - Flags-only write of all ones sets all four flags only.
// - Every transfer completes in one cycle with no extra cycles.
// - Flag-setting move into program counter restores current word from saved; outside the five banked modes it has no effect.
// - Test and compare update flags without set-flags unless a transfer or restore wins the cycle; others only when set-flags given.
// - Source bits 31 to 28 go to negative, zero, carry, overflow.
`timescale 1ns/1ps
module swt_status_word_transfer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Instruction issue
  input  wire logic        instr_valid_in,
  input  wire logic [31:0] instr_in,
  input  wire logic [31:0] src_value_in,
  // Data processing results
  input  wire logic        dp_valid_in,
  input  wire logic [3:0]  dp_opcode_in,
  input  wire logic        dp_set_flags_in,
  input  wire logic [3:0]  dp_alu_flags_in,
  input  wire logic        dp_pc_restore_in,
  // Register file write-back
  output logic             rd_write_out,
  output logic [3:0]       rd_index_out,
  output logic [31:0]      rd_data_out,
  // Status view
  output logic [31:0]      current_status_word_out,
  output logic [31:0]      saved_word_out,
  output logic             transfer_taken_out
);
  import swt_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0] current_status_word;
  logic [31:0] saved_status_word [SWT_BANKS];
  logic [31:0] next_current_status_word;
  logic [31:0] next_saved_status_word [SWT_BANKS];
  logic        next_rd_write;
  logic [3:0]  next_rd_index;
  logic [31:0] next_rd_data;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [4:0]  mode;
  logic        user_mode;
  logic [2:0]  bank;
  logic        bank_ok;
  logic        cond_pass;
  logic        is_xfer;
  logic        xfer_exec;
  logic        is_read;
  logic        is_full;
  logic        to_saved;
  logic [31:0] imm_value;
  logic [63:0] imm_double;
  logic [4:0]  rot_amount;
  logic [31:0] wr_value;
  logic [31:0] saved_now;
  logic        dp_flags;

  assign mode      = current_status_word[SWT_MODE_MSB:0];
  assign user_mode = (mode == SWT_MODE_USER);

  // Bank index from the mode in force now.
  always_comb begin
    bank_ok = 1'b1;
    unique case (mode)
      SWT_MODE_FIQ:   bank = 3'h0;
      SWT_MODE_IRQ:   bank = 3'h1;
      SWT_MODE_SVC:   bank = 3'h2;
      SWT_MODE_ABORT: bank = 3'h3;
      SWT_MODE_UNDEF: bank = 3'h4;
      default: begin
        bank    = 3'h0;
        bank_ok = 1'b0;
      end
    endcase
  end

  assign saved_now = bank_ok ? saved_status_word[bank] : 32'h00000000;

  swt_cond_eval u_cond (
    .cond_in  (instr_in[SWT_COND_MSB:SWT_COND_LSB]),
    .flags_in (current_status_word[SWT_FLAG_N_BIT:SWT_FLAG_V_BIT]),
    .pass_out (cond_pass)
  );

  assign is_xfer   = (instr_in[SWT_CLASS_MSB:SWT_CLASS_LSB] == SWT_CLASS_DP) &&
                     (instr_in[SWT_OPC_MSB:SWT_OPC_LSB] == SWT_OPC_TEST) &&
                     !instr_in[SWT_SETF_BIT];
  assign xfer_exec = instr_valid_in && is_xfer && cond_pass;
  assign is_read   = !instr_in[SWT_WRITE_BIT];
  assign is_full   = instr_in[SWT_FULL_BIT];
  assign to_saved  = instr_in[SWT_SAVED_BIT];

  // Rotated eight-bit immediate, rotated right by twice the rotate field.
  assign rot_amount = {instr_in[SWT_ROT_MSB:SWT_ROT_LSB], 1'b0};
  assign imm_double = {24'h000000, instr_in[SWT_IMM8_MSB:0], 24'h000000, instr_in[SWT_IMM8_MSB:0]} >> rot_amount;
  assign imm_value  = imm_double[31:0];
  assign wr_value   = (instr_in[SWT_IMM_BIT] && !is_full) ? imm_value : src_value_in;

  assign dp_flags = dp_valid_in && (dp_set_flags_in ||
                    (dp_opcode_in >= SWT_DP_TST && dp_opcode_in <= SWT_DP_CMN));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_current_status_word = current_status_word;
    next_saved_status_word   = saved_status_word;
    next_rd_write            = 1'b0;
    next_rd_index            = rd_index_out;
    next_rd_data             = rd_data_out;
    if (xfer_exec) begin
      if (is_read) begin
        next_rd_write = 1'b1;
        next_rd_index = instr_in[SWT_RD_MSB:SWT_RD_LSB];
        next_rd_data  = to_saved ? saved_now : current_status_word;
      end else if (to_saved) begin
        if (bank_ok) begin
          if (is_full) begin
            next_saved_status_word[bank] = wr_value & SWT_DEFINED_MASK;
          end else begin
            next_saved_status_word[bank] = {wr_value[31:28], saved_now[27:0]};
          end
        end
      end else if (is_full && !user_mode) begin
        next_current_status_word = wr_value & SWT_DEFINED_MASK;
      end else begin
        next_current_status_word = {wr_value[31:28], current_status_word[27:0]};
      end
    end else if (dp_valid_in && dp_pc_restore_in) begin
      if (bank_ok) begin
        next_current_status_word = saved_now;
      end
    end else if (dp_flags) begin
      next_current_status_word = {dp_alu_flags_in, current_status_word[27:0]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      current_status_word <= SWT_CURRENT_RESET;
      for (int i = 0; i < SWT_BANKS; i++) begin
        saved_status_word[i] <= SWT_SAVED_RESET;
      end
      rd_write_out <= 1'b0;
      rd_index_out <= 4'h0;
      rd_data_out  <= 32'h00000000;
    end else begin
      current_status_word <= next_current_status_word & SWT_DEFINED_MASK;
      for (int i = 0; i < SWT_BANKS; i++) begin
        saved_status_word[i] <= next_saved_status_word[i] & SWT_DEFINED_MASK;
      end
      rd_write_out <= next_rd_write;
      rd_index_out <= next_rd_index;
      rd_data_out  <= next_rd_data;
    end
  end

  assign current_status_word_out = current_status_word;
  assign saved_word_out          = saved_now;
  assign transfer_taken_out      = xfer_exec;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  logic cur_write;
  assign cur_write = xfer_exec && !is_read && !to_saved;

  sequence s_issue_flags_cur;
    cur_write && !is_full;
  endsequence

  a_cond_blocks_read: assert property (instr_valid_in && is_xfer && !cond_pass && !dp_valid_in
    |=> !rd_write_out && $stable(current_status_word))
    else $error("failed condition still had an effect");

  a_read_one_cycle: assert property (xfer_exec && is_read
    |=> rd_write_out && rd_data_out == ($past(to_saved) ? $past(saved_now) : $past(current_status_word)))
    else $error("status read returned wrong data or late");

  a_write_one_cycle: assert property (xfer_exec && is_read ##1 !xfer_exec |=> !rd_write_out)
    else $error("read write-back lasted more than one cycle");

  a_flags_only_cur: assert property (s_issue_flags_cur
    |=> current_status_word[31:28] == $past(wr_value[31:28]) &&
        current_status_word[27:0] == $past(current_status_word[27:0]))
    else $error("flags-only write disturbed control bits");

  a_all_flags_set: assert property (s_issue_flags_cur and (wr_value[31:28] == 4'hf)
    |=> current_status_word[31:28] == 4'hf && $stable(current_status_word[7:0]))
    else $error("all-ones flags write did not set every flag");

  a_user_protect: assert property (cur_write && user_mode
    |=> current_status_word[27:0] == $past(current_status_word[27:0]))
    else $error("user mode changed control bits");

  a_priv_full_write: assert property (cur_write && is_full && !user_mode
    |=> current_status_word == ($past(src_value_in) & SWT_DEFINED_MASK))
    else $error("privileged full write not taken");

  a_bank_select: assert property (xfer_exec && !is_read && to_saved && is_full && bank_ok
    |=> saved_word_out == ($past(src_value_in) & SWT_DEFINED_MASK))
    else $error("saved write went to the wrong bank");

  a_reserved_zero: assert property (((current_status_word_out | rd_data_out | saved_word_out)
    & ~SWT_DEFINED_MASK) == 32'h00000000)
    else $error("reserved status bits read as nonzero");

  a_pc_restore: assert property (!xfer_exec && dp_valid_in && dp_pc_restore_in && bank_ok
    |=> current_status_word == $past(saved_now))
    else $error("saved word not restored on move into pc");

  a_test_flags: assert property (!xfer_exec && dp_valid_in && !dp_pc_restore_in &&
    dp_opcode_in == SWT_DP_TST |=> current_status_word[31:28] == $past(dp_alu_flags_in))
    else $error("test opcode did not update flags");

endmodule

/* File: testbench/swt_status_word_transfer_test.sv */
// Self-checking bench for the status word transfer block.
// Assumes the block alone, driven directly at its ports from one 100 MHz clock.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module swt_status_word_transfer_test;
  import swt_pkg::*;
  logic        clk_in;
  logic        reset_in;
  logic        instr_valid_in;
  logic [31:0] instr_in;
  logic [31:0] src_value_in;
  logic        dp_valid_in;
  logic [3:0]  dp_opcode_in;
  logic        dp_set_flags_in;
  logic [3:0]  dp_alu_flags_in;
  logic        dp_pc_restore_in;
  logic        rd_write_out;
  logic [3:0]  rd_index_out;
  logic [31:0] rd_data_out;
  logic [31:0] current_status_word_out;
  logic [31:0] saved_word_out;
  logic        transfer_taken_out;
  int          n_mismatch = 0;
  int          tests_run = 0;

  swt_status_word_transfer i_swt_status_word_transfer (
    .clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .src_value_in(src_value_in), .dp_valid_in(dp_valid_in), .dp_opcode_in(dp_opcode_in),
    .dp_set_flags_in(dp_set_flags_in), .dp_alu_flags_in(dp_alu_flags_in),
    .dp_pc_restore_in(dp_pc_restore_in), .rd_write_out(rd_write_out), .rd_index_out(rd_index_out),
    .rd_data_out(rd_data_out), .current_status_word_out(current_status_word_out),
    .saved_word_out(saved_word_out), .transfer_taken_out(transfer_taken_out));

  always #5 clk_in = ~clk_in;

  // ****************************************************************
  // Drivers
  // ****************************************************************
  // Builds a transfer word: condition, saved select, write, full, immediate, Rd, low field.
  function automatic logic [31:0] op(input logic [3:0] c, input logic s, input logic w, input logic f,
                                     input logic i, input logic [3:0] rd, input logic [11:0] lo);
    op = {c, 2'h0, i, 2'h2, s, w, 1'h0, 3'h4, f, rd, lo};
  endfunction

  task automatic xfer(input logic [31:0] ins, input logic [31:0] src, input logic take);
    @(posedge clk_in); #1;
    instr_valid_in = 1'h1;
    instr_in = ins;
    src_value_in = src;
    #1 `CHK(transfer_taken_out, take)
    @(posedge clk_in); #1;
    instr_valid_in = 1'h0;
    src_value_in = ~src;
  endtask

  task automatic dp(input logic [3:0] opc, input logic s, input logic [3:0] fl, input logic rs);
    @(posedge clk_in); #1;
    dp_valid_in = 1'h1;
    dp_opcode_in = opc;
    dp_set_flags_in = s;
    dp_alu_flags_in = fl;
    dp_pc_restore_in = rs;
    @(posedge clk_in); #1;
    dp_valid_in = 1'h0;
    dp_pc_restore_in = 1'h0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    `CHK(current_status_word_out, 32'h000000d3)
    `CHK(saved_word_out, 32'h00000000)
    `CHK(rd_write_out, 1'h0)
  endtask

  task automatic t_read();
    xfer(op(SWT_CC_AL, 1'h0, 1'h0, 1'h0, 1'h0, 4'h3, 12'h000), 32'h0, 1'h1);
    `CHK(rd_write_out, 1'h1)
    `CHK(rd_index_out, 4'h3)
    `CHK(rd_data_out, 32'h000000d3)
    @(posedge clk_in); #1;
    `CHK(rd_write_out, 1'h0)
  endtask

  task automatic t_banks();
    xfer(op(SWT_CC_AL, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 12'h000), 32'haffffff1, 1'h1);
    `CHK(current_status_word_out, 32'ha00000d1)
    `CHK(saved_word_out, 32'h00000000)
    xfer(op(SWT_CC_AL, 1'h1, 1'h1, 1'h1, 1'h0, 4'h0, 12'h000), 32'h6fffffd3, 1'h1);
    `CHK(saved_word_out, 32'h600000d3)
    xfer(op(SWT_CC_AL, 1'h1, 1'h0, 1'h0, 1'h0, 4'h5, 12'h000), 32'h0, 1'h1);
    `CHK(rd_data_out, 32'h600000d3)
    xfer(op(SWT_CC_AL, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 12'h000), 32'ha00000d2, 1'h1);
    `CHK(saved_word_out, 32'h00000000)
    xfer(op(SWT_CC_AL, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 12'h000), 32'ha00000d1, 1'h1);
    `CHK(saved_word_out, 32'h600000d3)
  endtask

  task automatic t_flags();
    xfer(op(SWT_CC_AL, 1'h0, 1'h1, 1'h0, 1'h1, 4'h0, 12'h4f0), 32'h0, 1'h1);
    `CHK(current_status_word_out, 32'hf00000d1)
    xfer(op(SWT_CC_AL, 1'h0, 1'h1, 1'h0, 1'h0, 4'h0, 12'h000), 32'h4fffffff, 1'h1);
    `CHK(current_status_word_out, 32'h400000d1)
    xfer(op(SWT_CC_AL, 1'h1, 1'h1, 1'h0, 1'h1, 4'h0, 12'h430), 32'h0, 1'h1);
    `CHK(saved_word_out, 32'h300000d3)
  endtask

  task automatic t_cond();
    xfer(op(SWT_CC_NE, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 12'h000), 32'h00000013, 1'h0);
    `CHK(current_status_word_out, 32'h400000d1)
    xfer(op(SWT_CC_EQ, 1'h0, 1'h1, 1'h0, 1'h0, 4'h0, 12'h000), 32'h80000000, 1'h1);
    `CHK(current_status_word_out, 32'h800000d1)
    xfer(op(SWT_CC_AL, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 12'h000) | 32'h00100000, 32'h00000013, 1'h0);
    `CHK(current_status_word_out, 32'h800000d1)
  endtask

  task automatic t_dp();
    dp(SWT_DP_TST, 1'h0, 4'h5, 1'h0);
    `CHK(current_status_word_out, 32'h500000d1)
    dp(4'h4, 1'h0, 4'ha, 1'h0);
    `CHK(current_status_word_out, 32'h500000d1)
    dp(4'h4, 1'h1, 4'ha, 1'h0);
    `CHK(current_status_word_out, 32'ha00000d1)
    dp(4'hd, 1'h1, 4'h0, 1'h1);
    `CHK(current_status_word_out, 32'h300000d3)
  endtask

  task automatic t_user();
    xfer(op(SWT_CC_AL, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 12'h000), 32'h000000d0, 1'h1);
    `CHK(current_status_word_out, 32'h000000d0)
    xfer(op(SWT_CC_AL, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 12'h000), 32'h5000001f, 1'h1);
    `CHK(current_status_word_out, 32'h500000d0)
    xfer(op(SWT_CC_AL, 1'h0, 1'h0, 1'h0, 1'h0, 4'h2, 12'h000), 32'h0, 1'h1);
    `CHK(rd_data_out, 32'h500000d0)
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end

  initial begin
    clk_in = 1'h0;
    reset_in = 1'h1;
    instr_valid_in = 1'h0;
    instr_in = 32'h0;
    src_value_in = 32'h0;
    dp_valid_in = 1'h0;
    dp_opcode_in = 4'h0;
    dp_set_flags_in = 1'h0;
    dp_alu_flags_in = 4'h0;
    dp_pc_restore_in = 1'h0;
    repeat (3) @(posedge clk_in);
    #1 reset_in = 1'h0;
    t_reset();
    t_read();
    t_banks();
    t_flags();
    t_cond();
    t_dp();
    t_user();
    summarize();
  end
endmodule
